// >>> rtl/dap_pkg.sv
/*
  Constants, types and parity helpers for the host-side AXI master that
  drives the write-data, write-response and read-address channels of the
  memory controller's direct-connect port.
  Assumes one clock and synchronous channel inputs.
*/
// Notes on behaviour
// [RQ1] Master sends 64 strobe bits per beat; only strobed byte lanes update.
// [RQ2] Write last flag is high on exactly the final beat of each burst.
// [RQ3] Master sends a 64-bit byte parity vector with each write beat.
// [RQ4] Write valid is raised only while data and strobes are valid.
// [RQ5] Controller raises write ready when it can take the offered data.
// [RQ6] Response ID equals the write address ID of the completed write.
// [RQ7] Controller reports 2-bit write status qualified by response valid.
// [RQ8] Master raises response ready when it can take the response.
// [RQ9] Each read request carries an 8-bit ID for the whole group.
// [RQ10] Master presents a 40-bit start address of the read burst.
// [RQ11] Read burst beat count travels on an 8-bit length field.
// [RQ12] Read transfer size travels on a 3-bit size field.
// [RQ13] 2-bit burst type plus size give each beat's address.
// [RQ14] Read QoS stays unchanged while valid is high and ready low.
// [RQ15] Port arbiter ranks reads by QoS, larger value wins.
// [RQ16] QoS also sets read CAM entry priority per port QoS config.
// [RQ17] Auto-precharge bit counts only while read valid is high.
// [RQ18] One address parity bit over whole address, configured parity type.
// [RQ19] Poisoned read returns all-zero data.
// [RQ20] Master not using poison holds poison input at zero.
// [RQ21] Urgent with port urgent enable makes arbiter switch to reads.
// [RQ22] Urgent may rise anytime, tied to no particular request.
// [RQ23] Read valid only while address and all controls are present.
// [RQ24] Read cache, protection and region are tied to zero.
// [RQ25] Transfer on edge with valid and ready; payload held until then.
package dap_pkg;

  // Channel widths
  localparam int DAP_DATA_W  = 512;
  localparam int DAP_STRB_W  = 64;
  localparam int DAP_ID_W    = 8;
  localparam int DAP_ADDR_W  = 40;
  localparam int DAP_LEN_W   = 8;
  localparam int DAP_SIZE_W  = 3;
  localparam int DAP_BURST_W = 2;
  localparam int DAP_QOS_W   = 4;
  localparam int DAP_RESP_W  = 2;
  localparam int DAP_CACHE_W = 4;
  localparam int DAP_PROT_W  = 3;
  localparam int DAP_REG_W   = 4;

  // Write-data hold layout: data, strobes, parity, last
  localparam int DAP_W_STRB_LSB = DAP_DATA_W;
  localparam int DAP_W_PAR_LSB  = DAP_W_STRB_LSB + DAP_STRB_W;
  localparam int DAP_W_LAST_BIT = DAP_W_PAR_LSB + DAP_STRB_W;
  localparam int DAP_W_HOLD_W   = DAP_W_LAST_BIT + 1;

  // Read-address hold layout
  localparam int DAP_AR_ADDR_LSB  = DAP_ID_W;
  localparam int DAP_AR_LEN_LSB   = DAP_AR_ADDR_LSB + DAP_ADDR_W;
  localparam int DAP_AR_SIZE_LSB  = DAP_AR_LEN_LSB + DAP_LEN_W;
  localparam int DAP_AR_BURST_LSB = DAP_AR_SIZE_LSB + DAP_SIZE_W;
  localparam int DAP_AR_QOS_LSB   = DAP_AR_BURST_LSB + DAP_BURST_W;
  localparam int DAP_AR_LOCK_BIT  = DAP_AR_QOS_LSB + DAP_QOS_W;
  localparam int DAP_AR_AP_BIT    = DAP_AR_LOCK_BIT + 1;
  localparam int DAP_AR_PAR_BIT   = DAP_AR_AP_BIT + 1;
  localparam int DAP_AR_POIS_BIT  = DAP_AR_PAR_BIT + 1;
  localparam int DAP_AR_HOLD_W    = DAP_AR_POIS_BIT + 1;

  // Reset and tie-off values
  localparam logic [DAP_LEN_W-1:0]   DAP_LEN_RST  = 8'h00;
  localparam logic [DAP_ID_W-1:0]    DAP_ID_RST   = 8'h00;
  localparam logic [DAP_RESP_W-1:0]  DAP_RESP_RST = 2'h0;
  localparam logic [DAP_CACHE_W-1:0] DAP_CACHE_TIE = 4'h0;
  localparam logic [DAP_PROT_W-1:0]  DAP_PROT_TIE  = 3'h0;
  localparam logic [DAP_REG_W-1:0]   DAP_REG_TIE   = 4'h0;

  // Write burst sequencer states
  typedef enum logic [0:0] {
    DAP_WR_IDLE = 1'b0,
    DAP_WR_DATA = 1'b1
  } dap_wr_st_t;

  // Byte-wise parity of one beat; odd flips every bit
  function automatic logic [DAP_STRB_W-1:0] dap_byte_par(
    input logic [DAP_DATA_W-1:0] data,
    input logic                  odd
  );
    logic [DAP_STRB_W-1:0] p;
    p = '0;
    for (int i = 0; i < DAP_STRB_W; i++) begin
      p[i] = (^data[i*8 +: 8]) ^ odd;
    end
    return p;
  endfunction

  // Single parity bit over the whole address
  function automatic logic dap_addr_par(
    input logic [DAP_ADDR_W-1:0] addr,
    input logic                  odd
  );
    return (^addr) ^ odd;
  endfunction

endpackage

// >>> rtl/dap_par_gen.sv
/*
  Parity generator for write beats and read addresses.
  Assumes the parity type input matches the controller's parity setting.
*/
module dap_par_gen
  import dap_pkg::*;
(
  input  wire logic [DAP_DATA_W-1:0] data,     // Write beat data
  input  wire logic [DAP_ADDR_W-1:0] addr,     // Read start address
  input  wire logic                  par_odd,  // 1 = odd parity type
  output logic      [DAP_STRB_W-1:0] data_par, // Per-byte parity
  output logic                       addr_par  // Whole-address parity
);

  // Both parities from shared helpers
  assign data_par = dap_byte_par(data, par_odd);  // RQ3
  assign addr_par = dap_addr_par(addr, par_odd);  // RQ18

endmodule

// >>> rtl/dap_hold.sv
/*
  One-entry channel register: captures a payload from the user side and
  presents it to the link, holding it until valid and ready meet.
  Assumes the link side follows the ordinary valid/ready handshake.
*/
module dap_hold
  import dap_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         clk,       // System clock
  input  wire logic         rstn,      // Async reset, active low
  input  wire logic         in_valid,  // User payload offered
  output logic              in_ready,  // Entry free or draining
  input  wire logic [W-1:0] in_data,   // User payload
  output logic              out_valid, // Link valid
  input  wire logic         out_ready, // Link ready
  output logic      [W-1:0] out_data   // Link payload, from flops
);

  logic full_r;
  logic [W-1:0] data_r;

  // Accept when empty or when the held entry leaves this cycle
  assign in_ready  = !full_r || out_ready;
  assign out_valid = full_r;
  assign out_data  = data_r;

  // Occupancy
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      full_r <= 1'b0;
    end else if (in_valid && in_ready) begin
      full_r <= 1'b1;
    end else if (out_ready) begin
      full_r <= 1'b0;  // RQ25
    end
  end

  // Payload changes only on a fresh load
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      data_r <= '0;
    end else if (in_valid && in_ready) begin
      data_r <= in_data;  // RQ25
    end
  end

endmodule

// >>> rtl/dap_host.sv
/*
  Host-side AXI master for the direct-connect port: write-data channel,
  write-response channel and read-address channel with sidebands.
  Assumes the write address for each burst is issued elsewhere and that
  the controller answers with ordinary valid/ready signalling.
*/
module dap_host
  import dap_pkg::*;
(
  input  wire logic                   clk,            // 50 MHz clock
  input  wire logic                   rstn,           // Async reset, low
  input  wire logic                   par_odd,        // Parity type, 1=odd
  // User write-burst command
  input  wire logic                   wr_start,       // Start a burst
  input  wire logic [DAP_LEN_W-1:0]   wr_len,         // Beats minus one
  output logic                        wr_start_ready, // Burst accepted
  // User write beats
  input  wire logic                   u_wvalid,       // Beat offered
  output logic                        u_wready,       // Beat taken
  input  wire logic [DAP_DATA_W-1:0]  u_wdata,        // Beat data
  input  wire logic [DAP_STRB_W-1:0]  u_wstrb,        // Byte lanes
  // User write response
  output logic                        u_bvalid,       // Response held
  input  wire logic                   u_bready,       // Response taken
  output logic      [DAP_ID_W-1:0]    u_bid,          // Response ID
  output logic      [DAP_RESP_W-1:0]  u_bresp,        // Response status
  // User read request
  input  wire logic                   u_arvalid,      // Request offered
  output logic                        u_arready,      // Request taken
  input  wire logic [DAP_ID_W-1:0]    u_arid,         // Request ID
  input  wire logic [DAP_ADDR_W-1:0]  u_araddr,       // Start address
  input  wire logic [DAP_LEN_W-1:0]   u_arlen,        // Beats minus one
  input  wire logic [DAP_SIZE_W-1:0]  u_arsize,       // Transfer size
  input  wire logic [DAP_BURST_W-1:0] u_arburst,      // Burst type
  input  wire logic                   u_arlock,       // Lock type
  input  wire logic [DAP_QOS_W-1:0]   u_arqos,        // Read QoS
  input  wire logic                   u_ar_ap,        // Auto-precharge
  input  wire logic                   u_ar_poison,    // Poison request
  input  wire logic                   u_urgent,       // Read urgent level
  // Write-data channel
  output logic      [DAP_DATA_W-1:0]  wdata,          // Write data
  output logic      [DAP_STRB_W-1:0]  wstrb,          // Byte strobes
  output logic                        wlast,          // Final beat
  output logic      [DAP_STRB_W-1:0]  wex_parity,     // Byte parity
  output logic                        wvalid,         // Write valid
  input  wire logic                   wready,         // Write ready
  // Write-response channel
  input  wire logic [DAP_ID_W-1:0]    bid,            // Response ID
  input  wire logic [DAP_RESP_W-1:0]  bresp,          // Response status
  input  wire logic                   bvalid,         // Response valid
  output logic                        bready,         // Response ready
  // Read-address channel
  output logic      [DAP_ID_W-1:0]    arid,           // Read ID
  output logic      [DAP_ADDR_W-1:0]  araddr,         // Read address
  output logic      [DAP_LEN_W-1:0]   arlen,          // Burst length
  output logic      [DAP_SIZE_W-1:0]  arsize,         // Burst size
  output logic      [DAP_BURST_W-1:0] arburst,        // Burst type
  output logic                        arlock,         // Lock type
  output logic      [DAP_CACHE_W-1:0] arcache,        // Cache type, zero
  output logic      [DAP_PROT_W-1:0]  arprot,         // Protection, zero
  output logic      [DAP_QOS_W-1:0]   arqos,          // Read QoS
  output logic      [DAP_REG_W-1:0]   arregion,       // Region, zero
  output logic                        arex_auto_precharge, // Precharge
  output logic                        arex_parity,    // Address parity
  output logic                        arex_poison,    // Read poison
  output logic                        arex_urgent,    // Read urgent
  output logic                        arvalid,        // Read addr valid
  input  wire logic                   arready         // Read addr ready
);

  dap_wr_st_t            wr_st_r;
  logic [DAP_LEN_W-1:0]  len_r;
  logic [DAP_LEN_W-1:0]  cnt_r;
  logic [DAP_LEN_W-1:0]  lk_cnt_r;
  logic                  resp_valid_r;
  logic [DAP_ID_W-1:0]   resp_id_r;
  logic [DAP_RESP_W-1:0] resp_code_r;
  logic                  urgent_r;
  logic [DAP_STRB_W-1:0] beat_par;
  logic                  ar_par;
  logic                  w_in_valid;
  logic                  w_in_ready;
  logic                  beat_last;
  logic [DAP_W_HOLD_W-1:0]  w_in;
  logic [DAP_W_HOLD_W-1:0]  w_out;
  logic [DAP_AR_HOLD_W-1:0] ar_in;
  logic [DAP_AR_HOLD_W-1:0] ar_out;
  logic                  ar_valid_i;

  // Parity for the beat and address being loaded
  dap_par_gen u_par (
    .data     (u_wdata),
    .addr     (u_araddr),
    .par_odd  (par_odd),
    .data_par (beat_par),
    .addr_par (ar_par)
  );

  // Burst start only when the previous burst has fully left
  assign wr_start_ready = (wr_st_r == DAP_WR_IDLE) && !wvalid;
  assign beat_last      = (cnt_r == len_r);
  assign w_in_valid     = (wr_st_r == DAP_WR_DATA) && u_wvalid;
  assign u_wready       = (wr_st_r == DAP_WR_DATA) && w_in_ready;

  // Beat payload: user strobes pass unchanged to the controller
  assign w_in = {beat_last, beat_par, u_wstrb, u_wdata};  // RQ1 RQ3

  // Burst sequencer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_st_r <= DAP_WR_IDLE;
    end else begin
      case (wr_st_r)
        DAP_WR_IDLE: begin
          if (wr_start && wr_start_ready) begin
            wr_st_r <= DAP_WR_DATA;
          end
        end
        DAP_WR_DATA: begin
          if (w_in_valid && w_in_ready && beat_last) begin
            wr_st_r <= DAP_WR_IDLE;
          end
        end
        default: begin
          wr_st_r <= DAP_WR_IDLE;
        end
      endcase
    end
  end

  // Burst length latch
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      len_r <= DAP_LEN_RST;
    end else if (wr_start && wr_start_ready) begin
      len_r <= wr_len;
    end
  end

  // User-side beat counter marks the final beat
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= DAP_LEN_RST;
    end else if (wr_start && wr_start_ready) begin
      cnt_r <= DAP_LEN_RST;
    end else if (w_in_valid && w_in_ready) begin
      cnt_r <= cnt_r + 8'h01;  // RQ2
    end
  end

  // Link-side beat counter, back to zero after the last beat
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lk_cnt_r <= DAP_LEN_RST;
    end else if (wvalid && wready) begin
      lk_cnt_r <= wlast ? DAP_LEN_RST : lk_cnt_r + 8'h01;
    end
  end

  // Write-data channel register
  dap_hold #(.W(DAP_W_HOLD_W)) u_w_hold (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (w_in_valid),
    .in_ready  (w_in_ready),
    .in_data   (w_in),
    .out_valid (wvalid),
    .out_ready (wready),
    .out_data  (w_out)
  );

  // Write-data outputs; valid only with a held beat
  assign wdata      = w_out[DAP_DATA_W-1:0];                     // RQ4
  assign wstrb      = w_out[DAP_W_STRB_LSB +: DAP_STRB_W];       // RQ1
  assign wex_parity = w_out[DAP_W_PAR_LSB +: DAP_STRB_W];        // RQ3
  assign wlast      = wvalid && w_out[DAP_W_LAST_BIT];           // RQ2

  // Response slot: ready only while empty
  assign bready   = !resp_valid_r;  // RQ8
  assign u_bvalid = resp_valid_r;
  assign u_bid    = resp_id_r;
  assign u_bresp  = resp_code_r;

  // Response slot occupancy
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      resp_valid_r <= 1'b0;
    end else if (bvalid && bready) begin
      resp_valid_r <= 1'b1;  // RQ7
    end else if (u_bready) begin
      resp_valid_r <= 1'b0;
    end
  end

  // Response ID and status capture
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      resp_id_r   <= DAP_ID_RST;
      resp_code_r <= DAP_RESP_RST;
    end else if (bvalid && bready) begin
      resp_id_r   <= bid;    // RQ6
      resp_code_r <= bresp;  // RQ7
    end
  end

  // Read request payload with its address parity
  assign ar_in = {u_ar_poison, ar_par, u_ar_ap, u_arlock, u_arqos,
                  u_arburst, u_arsize, u_arlen, u_araddr, u_arid};  // RQ18

  // Read-address channel register
  dap_hold #(.W(DAP_AR_HOLD_W)) u_ar_hold (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (u_arvalid),
    .in_ready  (u_arready),
    .in_data   (ar_in),
    .out_valid (ar_valid_i),
    .out_ready (arready),
    .out_data  (ar_out)
  );

  // Read-address fields, all from one held entry
  assign arvalid = ar_valid_i;                                   // RQ23
  assign arid    = ar_out[DAP_ID_W-1:0];                         // RQ9
  assign araddr  = ar_out[DAP_AR_ADDR_LSB +: DAP_ADDR_W];        // RQ10
  assign arlen   = ar_out[DAP_AR_LEN_LSB +: DAP_LEN_W];          // RQ11
  assign arsize  = ar_out[DAP_AR_SIZE_LSB +: DAP_SIZE_W];        // RQ12
  assign arburst = ar_out[DAP_AR_BURST_LSB +: DAP_BURST_W];      // RQ13
  assign arqos   = ar_out[DAP_AR_QOS_LSB +: DAP_QOS_W];          // RQ14
  assign arlock  = ar_out[DAP_AR_LOCK_BIT];
  assign arex_parity = ar_out[DAP_AR_PAR_BIT];                   // RQ18
  assign arex_poison = ar_valid_i && ar_out[DAP_AR_POIS_BIT];    // RQ20
  assign arex_auto_precharge = ar_valid_i && ar_out[DAP_AR_AP_BIT]; // RQ17

  // Unused attributes tied off
  assign arcache  = DAP_CACHE_TIE;  // RQ24
  assign arprot   = DAP_PROT_TIE;   // RQ24
  assign arregion = DAP_REG_TIE;    // RQ24

  // Urgent is a free-running level, independent of any request
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      urgent_r <= 1'b0;
    end else begin
      urgent_r <= u_urgent;  // RQ22
    end
  end
  assign arex_urgent = urgent_r;

  // Handshake sequences
  sequence s_w_wait;
    wvalid && !wready;
  endsequence

  sequence s_ar_wait;
    arvalid && !arready;
  endsequence

  sequence s_b_take;
    bvalid && bready;
  endsequence

  // Last flag exactly on the final link beat
  property p_wlast_final;
    @(posedge clk) disable iff (!rstn)
      (wvalid && (lk_cnt_r == len_r)) |-> wlast;
  endproperty
  a_wlast_final: assert property (p_wlast_final) // RQ2
    else $error("wlast missing on final beat");

  property p_wlast_early;
    @(posedge clk) disable iff (!rstn)
      (wvalid && (lk_cnt_r != len_r)) |-> !wlast;
  endproperty
  a_wlast_early: assert property (p_wlast_early) // RQ2
    else $error("wlast on an early beat");

  // Write payload held while stalled
  property p_w_stable;
    @(posedge clk) disable iff (!rstn)
      s_w_wait |=> wvalid && $stable(wdata) && $stable(wstrb)
                   && $stable(wlast);
  endproperty
  a_w_stable: assert property (p_w_stable) // RQ25
    else $error("write beat changed while stalled");

  // Beat parity matches the beat on the wire
  property p_w_par;
    @(posedge clk) disable iff (!rstn)
      wvalid |-> (wex_parity == dap_byte_par(wdata, par_odd));
  endproperty
  a_w_par: assert property (p_w_par) // RQ3
    else $error("write parity mismatch");

  // Read request held while stalled, QoS included
  property p_ar_stable;
    @(posedge clk) disable iff (!rstn)
      s_ar_wait |=> arvalid && $stable(arqos) && $stable(araddr)
                    && $stable(arid) && $stable(arlen);
  endproperty
  a_ar_stable: assert property (p_ar_stable) // RQ14
    else $error("read request changed while stalled");

  // Address parity matches the address
  property p_ar_par;
    @(posedge clk) disable iff (!rstn)
      arvalid |-> (arex_parity == dap_addr_par(araddr, par_odd));
  endproperty
  a_ar_par: assert property (p_ar_par) // RQ18
    else $error("read address parity mismatch");

  // Precharge never shown without a request
  property p_ap_gate;
    @(posedge clk) disable iff (!rstn)
      !arvalid |-> !arex_auto_precharge && !arex_poison;
  endproperty
  a_ap_gate: assert property (p_ap_gate) // RQ17
    else $error("sideband shown without read valid");

  // Response captured with its ID and slot blocks the next one
  property p_b_capture;
    @(posedge clk) disable iff (!rstn)
      s_b_take |=> u_bvalid && !bready && (u_bid == $past(bid))
                   && (u_bresp == $past(bresp));
  endproperty
  a_b_capture: assert property (p_b_capture) // RQ6
    else $error("write response not captured");

  // Urgent follows the user level one cycle later
  property p_urgent;
    @(posedge clk) disable iff (!rstn)
      rstn |=> (arex_urgent == $past(u_urgent));
  endproperty
  a_urgent: assert property (p_urgent) // RQ22
    else $error("urgent did not follow its input");

endmodule

// >>> verification/dap_ctl_model.sv
/*
  Controller-side slave model for the direct-connect port: random write
  and read-address stalls, one write response per finished burst.
  Assumes the master waits for each response before its next burst.
*/
module dap_ctl_model
  import dap_pkg::*;
(
  input  wire logic                  clk,     // System clock
  input  wire logic                  rstn,    // Async reset, low
  input  wire logic                  wvalid,  // Write beat valid
  input  wire logic                  wlast,   // Final beat
  output logic                       wready,  // Write ready
  output logic      [DAP_ID_W-1:0]   bid,     // Response ID
  output logic      [DAP_RESP_W-1:0] bresp,   // Response status
  output logic                       bvalid,  // Response valid
  input  wire logic                  bready,  // Response ready
  input  wire logic                  arvalid, // Read addr valid
  output logic                       arready  // Read addr ready
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0]         lf_r;
  logic [DAP_ID_W-1:0] id_r;
  logic                pend_r;

  // Stall pattern and single response slot
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lf_r    <= 16'h5A3C;
      wready  <= 1'b0;
      arready <= 1'b0;
      bvalid  <= 1'b0;
      bid     <= '0;
      bresp   <= '0;
      id_r    <= '0;
      pend_r  <= 1'b0;
    end else begin
      lf_r    <= {lf_r[14:0], lf_r[15] ^ lf_r[13] ^ lf_r[12] ^ lf_r[10]};
      wready  <= lf_r[0] | lf_r[1];
      arready <= lf_r[2] | lf_r[3];
      if (wvalid && wready && wlast) begin
        pend_r <= 1'b1;
      end
      if (pend_r && !bvalid && lf_r[6]) begin
        bvalid <= 1'b1;
        bid    <= id_r;
        bresp  <= lf_r[5:4];
        id_r   <= id_r + 8'h01;
        pend_r <= 1'b0;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
        bid    <= ~bid;
        bresp  <= ~bresp;
      end
    end
  end
endmodule

// >>> verification/ddr_axi_direct_port_wr_rdaddr_tb.sv
/*
  Self-checking bench for dap_host with a controller slave model.
  Assumes the package widths and the hand-over timing of the host.
*/
module ddr_axi_direct_port_wr_rdaddr_tb
  import dap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, rstn, par_odd, wr_start, u_wvalid, u_bready, u_arvalid, u_arlock;
  logic u_ar_ap, u_ar_poison, u_urgent, wready, bvalid, arready, wlast;
  logic wr_start_ready, u_wready, u_bvalid, u_arready, wvalid, bready;
  logic arlock, arex_auto_precharge, arex_parity, arex_poison, arex_urgent;
  logic arvalid, urg_q, urg_ok, w_hold, ar_hold;
  logic [DAP_LEN_W-1:0]   wr_len, u_arlen, arlen;
  logic [DAP_DATA_W-1:0]  u_wdata, wdata;
  logic [DAP_STRB_W-1:0]  u_wstrb, wstrb, wex_parity;
  logic [DAP_ID_W-1:0]    u_bid, bid, u_arid, arid;
  logic [DAP_RESP_W-1:0]  u_bresp, bresp;
  logic [DAP_ADDR_W-1:0]  u_araddr, araddr;
  logic [DAP_SIZE_W-1:0]  u_arsize, arsize;
  logic [DAP_BURST_W-1:0] u_arburst, arburst;
  logic [DAP_QOS_W-1:0]   u_arqos, arqos;
  logic [DAP_CACHE_W-1:0] arcache;
  logic [DAP_PROT_W-1:0]  arprot;
  logic [DAP_REG_W-1:0]   arregion;
  logic [15:0]            seed, bg;
  logic [9:0]             b_exp;
  logic [68:0]            ar_link, ar_prev;
  logic [640:0]           w_link, w_prev;
  logic [576:0]           we;
  logic [576:0]           wq[$];
  logic [68:0]            aq[$];
  int                     fail_count, checks, got_b, cyc;

  dap_host u_dut (.clk, .rstn, .par_odd, .wr_start, .wr_len, .wr_start_ready,
    .u_wvalid, .u_wready, .u_wdata, .u_wstrb, .u_bvalid, .u_bready, .u_bid,
    .u_bresp, .u_arvalid, .u_arready, .u_arid, .u_araddr, .u_arlen,
    .u_arsize, .u_arburst, .u_arlock, .u_arqos, .u_ar_ap, .u_ar_poison,
    .u_urgent, .wdata, .wstrb, .wlast, .wex_parity, .wvalid, .wready, .bid,
    .bresp, .bvalid, .bready, .arid, .araddr, .arlen, .arsize, .arburst,
    .arlock, .arcache, .arprot, .arqos, .arregion, .arex_auto_precharge,
    .arex_parity, .arex_poison, .arex_urgent, .arvalid, .arready);

  dap_ctl_model u_ctl (.clk, .rstn, .wvalid, .wlast, .wready, .bid, .bresp,
    .bvalid, .bready, .arvalid, .arready);

  // Link views for comparison
  assign ar_link = {arid, araddr, arlen, arsize, arburst, arlock, arqos,
                    arex_auto_precharge, arex_poison, arex_parity};
  assign w_link  = {wdata, wstrb, wlast, wex_parity};

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [15:0] rnd();
    seed = lfsr(seed);
    return seed;
  endfunction

  // Expected byte parity of one beat
  function automatic logic [63:0] bpar(input logic [511:0] d);
    for (int i = 0; i < 64; i++) bpar[i] = ^d[8*i +: 8] ^ par_odd;
  endfunction

  task automatic chk(input string nm, input logic [703:0] e, g);
    checks++;
    if (e !== g) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Wait until a ready is settled high, then pass the taking edge
  task automatic wait_hs(input int k);
    do @(negedge clk);
    while (!(k == 0 ? wr_start_ready : k == 1 ? u_wready : u_arready));
    @(posedge clk);
  endtask

  task automatic wr_burst(input logic [DAP_LEN_W-1:0] len);
    logic [511:0] d;
    logic [63:0]  s;
    int           want;
    int           n;
    want = got_b + 1;
    n = 0;
    wr_start <= 1'b1;
    wr_len   <= len;
    wait_hs(0);
    wr_start <= 1'b0;
    for (int k = 0; k <= int'(len); k++) begin
      for (int j = 0; j < 32; j++) d[16*j +: 16] = rnd();
      s = (k == 1) ? '0 : {rnd(), rnd(), rnd(), rnd()};
      u_wvalid <= 1'b1;
      u_wdata  <= d;
      u_wstrb  <= s;
      wait_hs(1);
      wq.push_back({d, s, k == int'(len)});
    end
    u_wvalid <= 1'b0;
    while (got_b < want && n < 500) begin
      @(posedge clk);
      n++;
    end
    chk("response count", want, got_b);
  endtask

  task automatic rd_req(input logic [67:0] f);
    u_arvalid <= 1'b1;
    {u_arid, u_araddr, u_arlen, u_arsize, u_arburst, u_arlock, u_arqos,
     u_ar_ap, u_ar_poison} <= f;
    wait_hs(2);
    aq.push_back({f, ^f[59:20] ^ par_odd});
  endtask

  // Clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Link monitor, plus random response ready and urgent level
  always @(posedge clk) begin
    bg = lfsr(bg);
    u_bready <= bg[0];
    u_urgent <= bg[1] & bg[2];
    if (rstn !== 1'b1) begin
      urg_ok = 1'b0;
    end else begin
      if (wvalid === 1'b1 && wready === 1'b1) begin
        we = wq.pop_front();
        chk("w beat", we, {wdata, wstrb, wlast});
        chk("w parity", bpar(we[576:65]), wex_parity);
      end
      if (w_hold) chk("w stable", w_prev, w_link);
      w_hold = wvalid === 1'b1 && wready !== 1'b1;
      w_prev = w_link;
      if (arvalid === 1'b1 && arready === 1'b1)
        chk("ar fields", aq.pop_front(), ar_link);
      if (ar_hold) chk("ar stable", ar_prev, ar_link);
      ar_hold = arvalid === 1'b1 && arready !== 1'b1;
      ar_prev = ar_link;
      if (arvalid !== 1'b1)
        chk("ar idle", '0, {arex_auto_precharge, arex_poison});
      chk("ar tie-offs", 11'h000, {arcache, arprot, arregion});
      if (urg_ok) chk("urgent", urg_q, arex_urgent);
      urg_q  = u_urgent;
      urg_ok = 1'b1;
      if (u_bvalid === 1'b1) chk("bready full", 1'b0, bready);
      if (bvalid === 1'b1 && bready === 1'b1) b_exp = {bid, bresp};
      if (u_bvalid === 1'b1 && u_bready === 1'b1) begin
        chk("user resp", b_exp, {u_bid, u_bresp});
        got_b++;
      end
    end
  end

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      final_report();
    end
  end

  // Main sequence
  initial begin
    int n;
    {rstn, par_odd, wr_start, u_wvalid, u_arvalid, u_bready, u_urgent} = '0;
    {wr_len, u_wdata, u_wstrb, u_arid, u_araddr, u_arlen} = '0;
    {u_arsize, u_arburst, u_arlock, u_arqos, u_ar_ap, u_ar_poison} = '0;
    {urg_ok, w_hold, ar_hold, fail_count, checks, got_b, cyc} = '0;
    seed = 16'hD3DB;
    bg   = 16'hD3DB;
    repeat (8) @(posedge clk);
    chk("reset outputs", 4'h1, {wvalid, arvalid, u_bvalid, bready});
    rstn <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      wr_burst(8'h00);
      for (int t = 0; t < 6; t++) wr_burst(8'(rnd() % 16'h0005));
      par_odd <= p[0];
      rd_req('0);
      rd_req({8'hFF, 40'hFF_FFFF_FFFF, 20'hF_FFFF});
      for (int t = 0; t < 20; t++)
        rd_req(68'({rnd(), rnd(), rnd(), rnd(), rnd()}));
      u_arvalid <= 1'b0;
      $display("test parity %0d done", p);
    end
    wr_burst(8'hFF);
    $display("test long burst done");
    n = 0;
    while (wq.size() + aq.size() != 0 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk("queues empty", 0, wq.size() + aq.size());
    final_report();
  end
endmodule
